/* File: src/bte_engine.sv */
// Purpose: 2d block transfer engine fed by instruction buffers
// Assumes: memory port accepts one read at a time, in order
// Notes:   destination x is word aligned, source shift realigns
`timescale 1ns/1ps
`default_nettype none
`include "bte_regs.svh"
module bte_engine
	import bte_pkg::*;
(
	input  wire logic         clk_sys_in,
	input  wire logic         resetn_in,
	input  wire logic [7:0]   reg_addr_in,
	input  wire logic [31:0]  reg_wdata_in,
	input  wire logic         reg_wr_in,
	input  wire logic         reg_rd_in,
	output logic [31:0]       reg_rdata_out,
	output logic              rd_req_valid_out,
	input  wire logic         rd_req_ready_in,
	output logic [31:0]       rd_req_addr_out,
	input  wire logic         rd_data_valid_in,
	output logic              rd_data_ready_out,
	input  wire logic [127:0] rd_data_in,
	output logic              wr_valid_out,
	input  wire logic         wr_ready_in,
	output logic [31:0]       wr_addr_out,
	output logic [255:0]      wr_data_out,
	output logic [31:0]       wr_mask_out,
	output logic              handoff_valid_out,
	input  wire logic         handoff_ready_in,
	output logic [127:0]      handoff_desc_out,
	output logic              busy_out
);
	// ************************************************************
	// decode functions
	// ************************************************************
	function automatic logic [127:0] rop_apply(input logic [7:0] rop,
		input logic [127:0] p, input logic [127:0] s,
		input logic [127:0] d);
		logic [127:0] r;
		r = '0;
		for (int i = 0; i < 128; i++)
			r[i] = rop[{p[i], s[i], d[i]}];
		return r;
	endfunction

	// true when the rop result depends on the destination bit
	function automatic logic rop_needs_d(input logic [7:0] rop);
		return ((rop ^ (rop >> 1)) & 8'h55) != 8'h00;
	endfunction

	// per byte lane selector picks fg or bg byte of its pixel
	function automatic logic [127:0] expand(input logic [15:0] sel,
		input logic [1:0] bsh, input logic [31:0] fg,
		input logic [31:0] bg);
		logic [127:0] r;
		logic [1:0]   b;
		r = '0;
		b = '0;
		for (int i = 0; i < 16; i++) begin
			b = 2'(i) & ((2'b01 << bsh) - 2'b01);
			r[i*8 +: 8] = sel[i] ? fg[b*8 +: 8] : bg[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [15:0] trans_mask(input logic [127:0] s,
		input logic [127:0] d, input logic [1:0] bsh,
		input logic mode);
		logic [15:0] m;
		logic [31:0] sv;
		logic [31:0] dv;
		logic        eq;
		m  = '0;
		sv = '0;
		dv = '0;
		eq = 1'b0;
		for (int i = 0; i < 16; i++) begin
			sv = 32'(s[(i >> bsh) * (8 << bsh) +: 32]);
			dv = 32'(d[(i >> bsh) * (8 << bsh) +: 32]);
			if (bsh == 2'd0)
				eq = sv[7:0] == dv[7:0];
			else if (bsh == 2'd1)
				eq = sv[15:0] == dv[15:0];
			else
				eq = sv == dv;
			m[i] = mode ? eq : !eq;
		end
		return m;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	bte_st_t       st;
	bte_st_t       next_st;
	logic          fifo_valid;
	logic          fifo_pop;
	logic [127:0]  fifo_data;
	logic [127:0]  d;
	bte_kind_t     kind;
	logic [1:0]    bsh;
	logic [11:0]   col;
	logic [11:0]   rowr;
	logic [31:0]   dy;
	logic [31:0]   xb;
	logic          wide;
	logic          need_d;
	logic [31:0]   step;
	logic [31:0]   daddr;
	logic [31:0]   saddr;
	logic [15:0]   sel;
	logic [127:0]  srcv;
	logic [127:0]  patv;
	logic [127:0]  res;
	logic [31:0]   cmask;
	logic [15:0]   tmask;
	logic [255:0]  shifted;
	logic          last_col;
	logic          last_row;

	assign d      = st.desc;
	assign kind   = bte_kind_t'(d[`BTE_D_KIND]);
	assign bsh    = d[`BTE_D_BPP];
	assign need_d = rop_needs_d(d[`BTE_D_ROP]) || d[`BTE_D_TRANS];
	assign wide   = (kind == BTE_K_FILL) && !need_d;
	assign step   = wide ? 32'h0000_0020 : 32'h0000_0010;
	// start corner and walk direction come from the descriptor
	assign col  = d[`BTE_D_XNEG] ? d[`BTE_D_W] - 12'd1 - st.wx
		: st.wx;
	assign rowr = d[`BTE_D_YNEG] ? d[`BTE_D_H] - 12'd1 - st.ry
		: st.ry;
	assign dy    = 32'(d[`BTE_D_DSTY]) + 32'(rowr);
	assign xb    = 32'({d[43:36], 4'h0}) + 32'(col) * step;
	assign daddr = st.dbase + dy * 32'(st.pitch[15:0]) + xb;
	assign saddr = d[`BTE_D_SRC] + 32'(rowr) * 32'(st.pitch[31:16])
		+ ((kind == BTE_K_MONO) ? 32'(col) * 32'h0000_0002
		: 32'(col) * 32'h0000_0010);
	assign last_col = st.wx == d[`BTE_D_W] - 12'd1;
	assign last_row = st.ry == d[`BTE_D_H] - 12'd1;

	// ************************************************************
	// source operand forming
	// ************************************************************
	assign shifted = {st.src1, st.src0} >> {d[`BTE_D_SHIFT], 3'b000};
	always_comb begin
		sel = '0;
		for (int i = 0; i < 16; i++) begin
			// mono chunk holds one bit per pixel of this word
			if (kind == BTE_K_MONO)
				sel[i] = st.src0[{saddr[3:1], 4'h0} + 7'(i >> bsh)];
			else
				sel[i] = st.pat[{rowr[2:0],
					3'((xb + 32'(i)) >> bsh)}];
		end
	end
	assign patv = expand(sel, bsh, st.fg, st.bg);
	always_comb begin
		case (kind)
			BTE_K_MEM:  srcv = shifted[127:0];
			BTE_K_MONO: srcv = patv;
			BTE_K_FILL: srcv = expand(16'hFFFF, bsh, st.fg, st.bg);
			default:    srcv = {128{1'b1}};
		endcase
	end
	// pattern kind feeds the pattern operand, others a fixed one
	assign res = rop_apply(d[`BTE_D_ROP],
		(kind == BTE_K_PAT) ? patv : {128{1'b1}}, srcv, st.dstw);
	assign tmask = d[`BTE_D_TRANS]
		? trans_mask(srcv, st.dstw, bsh, d[`BTE_D_TMODE])
		: 16'hFFFF;
	generate
		for (genvar g = 0; g < 32; g++) begin : g_clip
			assign cmask[g] = (xb + 32'(g) >= 32'(st.clipx[15:0]))
				&& (xb + 32'(g) <= 32'(st.clipx[31:16]))
				&& (dy >= 32'(st.clipy[15:0]))
				&& (dy <= 32'(st.clipy[31:16]));
		end
	endgenerate

	// ************************************************************
	// read-return buffer
	// ************************************************************
	bte_fifo #(
		.W(128),
		.D(`BTE_FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in   (clk_sys_in),
		.resetn_in    (resetn_in),
		.in_valid_in  (rd_data_valid_in),
		.in_ready_out (rd_data_ready_out),
		.in_data_in   (rd_data_in),
		.out_valid_out(fifo_valid),
		.out_ready_in (fifo_pop),
		.out_data_out (fifo_data)
	);
	assign fifo_pop = st.issued && fifo_valid;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_st       = st;
		next_st.rdata = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`BTE_A_STATUS: next_st.rdata = {13'h0, st.fsm,
					st.ileft[14:0], busy_out};
				`BTE_A_IBASE:  next_st.rdata = st.ibase;
				`BTE_A_ICOUNT: next_st.rdata = {16'h0, st.ileft};
				`BTE_A_DBASE:  next_st.rdata = st.dbase;
				`BTE_A_PITCH:  next_st.rdata = st.pitch;
				`BTE_A_FG:     next_st.rdata = st.fg;
				`BTE_A_BG:     next_st.rdata = st.bg;
				`BTE_A_CLIPX:  next_st.rdata = st.clipx;
				`BTE_A_CLIPY:  next_st.rdata = st.clipy;
				`BTE_A_PATLO:  next_st.rdata = st.pat[31:0];
				`BTE_A_PATHI:  next_st.rdata = st.pat[63:32];
				`BTE_A_DONE:   next_st.rdata = {16'h0, st.done};
				default:       next_st.rdata = '0;
			endcase
		end
		// setup registers are locked while a batch runs
		if (reg_wr_in && st.fsm == BTE_IDLE) begin
			case (reg_addr_in)
				`BTE_A_CTRL: begin
					if (reg_wdata_in[0] && st.ileft != '0)
						next_st.fsm = BTE_FETCH;
				end
				`BTE_A_IBASE:  next_st.ibase = reg_wdata_in;
				`BTE_A_ICOUNT: next_st.ileft = reg_wdata_in[15:0];
				`BTE_A_DBASE:  next_st.dbase = reg_wdata_in;
				`BTE_A_PITCH:  next_st.pitch = reg_wdata_in;
				`BTE_A_FG:     next_st.fg = reg_wdata_in;
				`BTE_A_BG:     next_st.bg = reg_wdata_in;
				`BTE_A_CLIPX:  next_st.clipx = reg_wdata_in;
				`BTE_A_CLIPY:  next_st.clipy = reg_wdata_in;
				`BTE_A_PATLO:  next_st.pat[31:0] = reg_wdata_in;
				`BTE_A_PATHI:  next_st.pat[63:32] = reg_wdata_in;
				`BTE_A_DONE:   next_st.done = '0;
				default:       next_st.done = st.done;
			endcase
		end
		if (rd_req_valid_out && rd_req_ready_in)
			next_st.issued = 1'b1;
		case (st.fsm)
			BTE_IDLE: next_st.issued = 1'b0;
			BTE_FETCH: begin
				if (fifo_pop) begin
					next_st.issued = 1'b0;
					next_st.desc   = fifo_data;
					next_st.wx     = '0;
					next_st.ry     = '0;
					next_st.half   = 1'b0;
					next_st.ibase  = st.ibase + 32'h0000_0010;
					next_st.fsm    = (fifo_data[`BTE_D_OP] != 4'h0)
						? BTE_HAND : BTE_SRC;
				end
			end
			BTE_SRC: begin
				if (kind == BTE_K_PAT || kind == BTE_K_FILL)
					next_st.fsm = BTE_DST;
				else if (fifo_pop) begin
					next_st.issued = 1'b0;
					if (st.half) begin
						next_st.src1 = fifo_data;
						next_st.half = 1'b0;
						next_st.fsm  = BTE_DST;
					end else begin
						next_st.src0 = fifo_data;
						next_st.src1 = '0;
						// an unaligned source needs the following word
						if (kind == BTE_K_MEM && d[`BTE_D_SHIFT] != 4'h0)
							next_st.half = 1'b1;
						else
							next_st.fsm = BTE_DST;
					end
				end
			end
			BTE_DST: begin
				if (!need_d)
					next_st.fsm = BTE_CALC;
				else if (fifo_pop) begin
					next_st.issued = 1'b0;
					next_st.dstw   = fifo_data;
					next_st.fsm    = BTE_CALC;
				end
			end
			BTE_CALC: begin
				next_st.waddr = daddr;
				next_st.wdata = {res, res};
				next_st.wmask = cmask & (wide ? 32'hFFFF_FFFF
					: {16'h0000, tmask});
				next_st.fsm   = BTE_WRITE;
			end
			BTE_WRITE: begin
				if (wr_ready_in) begin
					next_st.wx  = last_col ? 12'd0 : st.wx + 12'd1;
					next_st.ry  = last_col ? st.ry + 12'd1 : st.ry;
					next_st.fsm = BTE_SRC;
					if (last_col && last_row) begin
						next_st.ileft = st.ileft - 16'd1;
						next_st.done  = st.done + 16'd1;
						next_st.fsm   = (st.ileft == 16'd1)
							? BTE_IDLE : BTE_FETCH;
					end
				end
			end
			BTE_HAND: begin
				if (handoff_ready_in) begin
					next_st.ileft = st.ileft - 16'd1;
					next_st.done  = st.done + 16'd1;
					next_st.fsm   = (st.ileft == 16'd1)
						? BTE_IDLE : BTE_FETCH;
				end
			end
			default: next_st.fsm = BTE_IDLE;
		endcase
	end

	// ************************************************************
	// registers and outputs
	// ************************************************************
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st       <= '0;
			st.fsm   <= BTE_IDLE;
			st.clipx <= `BTE_R_CLIPX;
			st.clipy <= `BTE_R_CLIPY;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		rd_req_valid_out = 1'b0;
		rd_req_addr_out  = saddr;
		if (!st.issued) begin
			case (st.fsm)
				BTE_FETCH: begin
					rd_req_valid_out = 1'b1;
					rd_req_addr_out  = st.ibase;
				end
				BTE_SRC: begin
					rd_req_valid_out = kind == BTE_K_MEM
						|| kind == BTE_K_MONO;
					rd_req_addr_out  = {saddr[31:4], 4'h0}
						+ (st.half ? 32'h0000_0010 : 32'h0000_0000);
				end
				BTE_DST: begin
					rd_req_valid_out = need_d;
					rd_req_addr_out  = daddr;
				end
				default: rd_req_valid_out = 1'b0;
			endcase
		end
	end

	assign wr_valid_out      = st.fsm == BTE_WRITE;
	assign wr_addr_out       = st.waddr;
	assign wr_data_out       = st.wdata;
	assign wr_mask_out       = st.wmask;
	assign handoff_valid_out = st.fsm == BTE_HAND;
	assign handoff_desc_out  = st.desc;
	assign busy_out          = st.fsm != BTE_IDLE;
	assign reg_rdata_out     = st.rdata;
endmodule
`default_nettype wire

/* File: src/bte_regs.svh */
// Purpose: offsets, field positions, reset values of the blit engine
// Assumes: byte addresses on a 32-bit register port
// Notes:   descriptor fields index one 128-bit instruction word
`ifndef BTE_REGS_SVH
`define BTE_REGS_SVH
// ************************************************************
// register offsets
// ************************************************************
`define BTE_A_CTRL     8'h00
`define BTE_A_STATUS   8'h04
`define BTE_A_IBASE    8'h08
`define BTE_A_ICOUNT   8'h0C
`define BTE_A_DBASE    8'h10
`define BTE_A_PITCH    8'h14
`define BTE_A_FG       8'h18
`define BTE_A_BG       8'h1C
`define BTE_A_CLIPX    8'h20
`define BTE_A_CLIPY    8'h24
`define BTE_A_PATLO    8'h28
`define BTE_A_PATHI    8'h2C
`define BTE_A_DONE     8'h30
// ************************************************************
// descriptor fields
// ************************************************************
`define BTE_D_SRC      31:0
`define BTE_D_DSTX     43:32
`define BTE_D_DSTY     55:44
`define BTE_D_W        67:56
`define BTE_D_H        79:68
`define BTE_D_ROP      87:80
`define BTE_D_KIND     89:88
`define BTE_D_TRANS    90
`define BTE_D_TMODE    91
`define BTE_D_XNEG     92
`define BTE_D_YNEG     93
`define BTE_D_BPP      95:94
`define BTE_D_SHIFT    99:96
`define BTE_D_OP       103:100
// ************************************************************
// reset values and sizes
// ************************************************************
`define BTE_R_CLIPX    32'hFFFF_0000
`define BTE_R_CLIPY    32'hFFFF_0000
`define BTE_R_ZERO     32'h0000_0000
`define BTE_FIFO_DEPTH 32
`endif

/* File: src/bte_pkg.sv */
// Purpose: types shared by the blit engine
// Assumes: constants live in bte_regs.svh
// Notes:   all engine state is one packed struct
package bte_pkg;
	typedef enum logic [2:0] {
		BTE_IDLE  = 3'b000,
		BTE_FETCH = 3'b001,
		BTE_SRC   = 3'b010,
		BTE_DST   = 3'b011,
		BTE_CALC  = 3'b100,
		BTE_WRITE = 3'b101,
		BTE_HAND  = 3'b110
	} bte_state_t;
	typedef enum logic [1:0] {
		BTE_K_MEM  = 2'b00,
		BTE_K_PAT  = 2'b01,
		BTE_K_FILL = 2'b10,
		BTE_K_MONO = 2'b11
	} bte_kind_t;
	typedef struct packed {
		bte_state_t    fsm;
		logic          issued;
		logic          half;
		logic [31:0]   ibase;
		logic [15:0]   ileft;
		logic [127:0]  desc;
		logic [31:0]   dbase;
		logic [31:0]   pitch;
		logic [31:0]   fg;
		logic [31:0]   bg;
		logic [31:0]   clipx;
		logic [31:0]   clipy;
		logic [63:0]   pat;
		logic [15:0]   done;
		logic [11:0]   wx;
		logic [11:0]   ry;
		logic [127:0]  src0;
		logic [127:0]  src1;
		logic [127:0]  dstw;
		logic [31:0]   waddr;
		logic [255:0]  wdata;
		logic [31:0]   wmask;
		logic [31:0]   rdata;
	} bte_st_t;
endpackage

/* File: src/bte_fifo.sv */
// Purpose: read-return buffer with valid/ready on both sides
// Assumes: one clock, depth a power of two
// Notes:   full and empty come from a count, no guessing
`timescale 1ns/1ps
`default_nettype none
module bte_fifo #(
	parameter int W = 128,
	parameter int D = 32
) (
	input  wire logic         clk_sys_in,
	input  wire logic         resetn_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic          push;
	logic          pop;
	assign in_ready_out  = (cnt != (AW+1)'(D));
	assign out_valid_out = (cnt != '0);
	assign out_data_out  = mem[rp];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (push)
			mem[wp] <= in_data_in;
	end
endmodule
`default_nettype wire

/* File: sim/bte_props.sv */
// Purpose: port assertions for the blit engine
// Assumes: one clock, async active-low reset
// Notes:   bound to every bte_engine instance
`timescale 1ns/1ps
`default_nettype none
`include "bte_regs.svh"
module bte_props (
	input wire logic         clk_sys_in,
	input wire logic         resetn_in,
	input wire logic         rd_req_valid_out,
	input wire logic         rd_req_ready_in,
	input wire logic [31:0]  rd_req_addr_out,
	input wire logic         wr_valid_out,
	input wire logic         wr_ready_in,
	input wire logic [31:0]  wr_addr_out,
	input wire logic [255:0] wr_data_out,
	input wire logic [31:0]  wr_mask_out,
	input wire logic         handoff_valid_out,
	input wire logic         handoff_ready_in,
	input wire logic [127:0] handoff_desc_out,
	input wire logic         busy_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// ********
	// handshakes and busy
	// ********
	a_req_hold: assert property (rd_req_valid_out && !rd_req_ready_in
		|=> rd_req_valid_out && $stable(rd_req_addr_out))
		else $error("read request dropped or moved");
	a_one_read: assert property (rd_req_valid_out && rd_req_ready_in
		|=> !rd_req_valid_out)
		else $error("second read while one outstanding");
	a_wr_hold: assert property (wr_valid_out && !wr_ready_in
		|=> wr_valid_out && $stable(wr_addr_out) && $stable(wr_data_out)
		&& $stable(wr_mask_out))
		else $error("write request dropped or changed");
	a_busy_cover: assert property (wr_valid_out || rd_req_valid_out
		|| handoff_valid_out |-> busy_out)
		else $error("memory activity while not busy");
	a_start_fetch: assert property ($rose(busy_out)
		|-> ##[0:4] rd_req_valid_out)
		else $error("no descriptor fetch after start");
	a_dup_half: assert property (wr_valid_out && wr_mask_out[31:16] == 0
		|-> wr_data_out[255:128] == wr_data_out[127:0])
		else $error("narrow write halves differ");
	a_hand_hold: assert property (handoff_valid_out && !handoff_ready_in
		|=> handoff_valid_out && $stable(handoff_desc_out))
		else $error("handoff dropped or changed");
	a_hand_op: assert property (handoff_valid_out
		|-> handoff_desc_out[`BTE_D_OP] != 4'h0)
		else $error("plain blit handed to renderer");
	a_one_port: assert property (wr_valid_out
		|-> !rd_req_valid_out && !handoff_valid_out)
		else $error("write overlaps read or handoff");
	a_busy_end: assert property ($fell(busy_out)
		|-> $past(wr_valid_out && wr_ready_in
		|| handoff_valid_out && handoff_ready_in))
		else $error("busy fell without final transfer");
	c_fill: cover property (wr_valid_out && wr_ready_in
		&& wr_mask_out == 32'hFFFF_FFFF);
	c_hand: cover property (handoff_valid_out && handoff_ready_in);
	c_stall: cover property (rd_req_valid_out && !rd_req_ready_in);
	c_done: cover property ($fell(busy_out));
endmodule
bind bte_engine bte_props i_props (.clk_sys_in, .resetn_in,
	.rd_req_valid_out, .rd_req_ready_in, .rd_req_addr_out, .wr_valid_out,
	.wr_ready_in, .wr_addr_out, .wr_data_out, .wr_mask_out,
	.handoff_valid_out, .handoff_ready_in, .handoff_desc_out, .busy_out);
`default_nettype wire

/* File: sim/bte_mem_model.sv */
// Purpose: memory side stand-in for the blit engine
// Assumes: one read outstanding, in-order return
// Notes:   slow_in stalls both ports and stretches latency
`timescale 1ns/1ps
`default_nettype none
module bte_mem_model #(
	parameter logic [31:0] IBASE = 32'h0000_1000
) (
	input  wire logic         clk_sys_in,
	input  wire logic         resetn_in,
	input  wire logic         slow_in,
	input  wire logic [127:0] desc0_in,
	input  wire logic [127:0] desc1_in,
	input  wire logic         rd_req_valid_in,
	input  wire logic [31:0]  rd_req_addr_in,
	output logic              rd_req_ready_out,
	output logic              rd_data_valid_out,
	input  wire logic         rd_data_ready_in,
	output logic [127:0]      rd_data_out,
	output logic              wr_ready_out
);
	// ********
	// request, latency, return
	// ********
	logic        pend;
	logic [2:0]  lat;
	logic [1:0]  tick;
	logic [31:0] pa;
	assign wr_ready_out     = !slow_in || tick == 2'h3;
	assign rd_req_ready_out = !pend && wr_ready_out;
	function automatic logic [127:0] word(input logic [31:0] a);
		if (a == IBASE)
			return desc0_in;
		if (a == IBASE + 32'h0000_0010)
			return desc1_in;
		return {a ^ 32'h3000_0000, a ^ 32'h2000_0000, a ^ 32'h1000_0000, a};
	endfunction
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pend              <= 1'b0;
			lat               <= 3'h0;
			tick              <= 2'h0;
			pa                <= 32'h0000_0000;
			rd_data_valid_out <= 1'b0;
			rd_data_out       <= '0;
		end else begin
			tick <= tick + 2'h1;
			if (rd_req_valid_in && rd_req_ready_out) begin
				pend <= 1'b1;
				pa   <= rd_req_addr_in;
				lat  <= slow_in ? 3'h5 : 3'h0;
			end else if (pend && lat != 3'h0) begin
				lat <= lat - 3'h1;
			end else if (pend && !rd_data_valid_out) begin
				rd_data_valid_out <= 1'b1;
				rd_data_out       <= word(pa);
			end else if (rd_data_valid_out && rd_data_ready_in) begin
				// released data line must not keep looking valid
				rd_data_valid_out <= 1'b0;
				pend              <= 1'b0;
				rd_data_out       <= ~rd_data_out;
			end
		end
	end
endmodule
`default_nettype wire

/* File: sim/block_transfer_raster_engine_test.sv */
// Purpose: self-checking bench for the blit engine
// Assumes: memory stand-in is bte_mem_model
// Notes:   small blocks keep the run short
`timescale 1ns/1ps
`default_nettype none
`include "bte_regs.svh"
module block_transfer_raster_engine_test;
	import bte_pkg::*;
	localparam logic [31:0] DB = 32'h0002_0000;
	localparam logic [31:0] FG = 32'hA5A5_0F0F;
	logic         clk = 1'b0;
	logic         rstn = 1'b0;
	logic [7:0]   ra = 8'h00;
	logic [31:0]  rw = 32'h0000_0000;
	logic         rwr = 1'b0, rrd = 1'b0, slow = 1'b0, hr = 1'b0;
	logic [2:0]   hc = 3'h0;
	logic [127:0] d0 = '0, d1 = '0, rd_d, hd, h_d;
	logic [31:0]  rdat, rq_a, wa, wm, w_a [4], w_m [4];
	logic [255:0] wd, w_d [4];
	logic         rq_v, rq_r, rd_v, rd_r, wv, wrdy, hv, busy;
	int           errors = 0, n_checks = 0, n_wr = 0, bytes = 0;
	int           n_h = 0, cyc = 0;
	bte_engine i_dut (.clk_sys_in(clk), .resetn_in(rstn), .reg_addr_in(ra),
		.reg_wdata_in(rw), .reg_wr_in(rwr), .reg_rd_in(rrd),
		.reg_rdata_out(rdat), .rd_req_valid_out(rq_v),
		.rd_req_ready_in(rq_r), .rd_req_addr_out(rq_a),
		.rd_data_valid_in(rd_v), .rd_data_ready_out(rd_r),
		.rd_data_in(rd_d), .wr_valid_out(wv), .wr_ready_in(wrdy),
		.wr_addr_out(wa), .wr_data_out(wd), .wr_mask_out(wm),
		.handoff_valid_out(hv), .handoff_ready_in(hr),
		.handoff_desc_out(hd), .busy_out(busy));
	bte_mem_model i_mem (.clk_sys_in(clk), .resetn_in(rstn), .slow_in(slow),
		.desc0_in(d0), .desc1_in(d1), .rd_req_valid_in(rq_v),
		.rd_req_addr_in(rq_a), .rd_req_ready_out(rq_r),
		.rd_data_valid_out(rd_v), .rd_data_ready_in(rd_r),
		.rd_data_out(rd_d), .wr_ready_out(wrdy));
	always #20 clk = ~clk;
	// ********
	// monitors, handoff partner, timeout
	// ********
	always @(posedge clk) begin
		cyc++;
		hc <= hv ? hc + 3'h1 : 3'h0;
		hr <= hv && hc == 3'h3 && !hr;
		if (hv && hr) begin
			h_d = hd;
			n_h++;
		end
		if (wv && wrdy) begin
			w_a[n_wr % 4] = wa;
			w_d[n_wr % 4] = wd;
			w_m[n_wr % 4] = wm;
			bytes += $countones(wm);
			n_wr++;
		end
		if (cyc == 30000) begin
			errors++;
			$display("ERROR cycles expected below 30000 seen %0d", cyc);
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [255:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ra  <= a;
		rw  <= d;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		ra  <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		#1;
		v = rdat;
	endtask
	task automatic start(input logic [15:0] n);
		n_wr = 0;
		bytes = 0;
		n_h = 0;
		// the base advances per descriptor, so each batch re-arms it
		wr(`BTE_A_IBASE, 32'h0000_1000);
		wr(`BTE_A_ICOUNT, {16'h0000, n});
		wr(`BTE_A_CTRL, 32'h0000_0001);
		#1;
	endtask
	task automatic idle();
		for (int k = 0; k < 2000 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
	endtask
	function automatic logic [127:0] mk(input logic [31:0] s,
		input logic [11:0] x, y, w, h, input logic [7:0] r,
		input logic [1:0] k, input logic [3:0] op);
		logic [127:0] d;
		d = '0;
		d[`BTE_D_SRC]  = s;
		d[`BTE_D_DSTX] = x;
		d[`BTE_D_DSTY] = y;
		d[`BTE_D_W]    = w;
		d[`BTE_D_H]    = h;
		d[`BTE_D_ROP]  = r;
		d[`BTE_D_KIND] = k;
		d[`BTE_D_OP]   = op;
		return d;
	endfunction
	function automatic logic [127:0] mw(input logic [31:0] a);
		return {a ^ 32'h3000_0000, a ^ 32'h2000_0000, a ^ 32'h1000_0000, a};
	endfunction
	// pattern bit is one for non-pattern sources
	function automatic logic [127:0] rop_f(input logic [7:0] r,
		input logic [127:0] s, d);
		logic [127:0] o;
		for (int i = 0; i < 128; i++)
			o[i] = r[{1'b1, s[i], d[i]}];
		return o;
	endfunction
	// ********
	// scenarios
	// ********
	task automatic t_reset();
		logic [31:0] v;
		rd(`BTE_A_CLIPX, v);
		chk("clipx", v, `BTE_R_CLIPX);
		rd(`BTE_A_CLIPY, v);
		chk("clipy", v, `BTE_R_CLIPY);
		rd(`BTE_A_STATUS, v);
		chk("status", v, `BTE_R_ZERO);
		rd(8'h3C, v);
		chk("unmapped", v, `BTE_R_ZERO);
		$display("test reset done");
	endtask
	task automatic t_batch();
		d0 <= mk(32'h0, 12'h020, 12'h002, 12'h001, 12'h001, 8'hCC,
			BTE_K_FILL, 4'h0);
		d1 <= mk(32'h7000, 12'h000, 12'h000, 12'h001, 12'h001, 8'hCC,
			BTE_K_MEM, 4'h1);
		start(16'h0002);
		idle();
		chk("fill writes", n_wr, 1);
		chk("fill addr", w_a[0], DB + 32'h0000_0220);
		// 8 bpp fill repeats the low colour byte in every lane
		chk("fill data", w_d[0], {32{FG[7:0]}});
		chk("fill mask", w_m[0], 32'hFFFF_FFFF);
		chk("handoffs", n_h, 1);
		chk("handoff desc", h_d, d1);
		$display("test batch done");
	endtask
	task automatic t_copy();
		logic [31:0] v, off;
		slow <= 1'b1;
		wr(`BTE_A_DONE, 32'h0000_0000);
		d0 <= mk(32'h0003_0040, 12'h030, 12'h001, 12'h002, 12'h002, 8'hCC,
			BTE_K_MEM, 4'h0);
		start(16'h0001);
		rd(`BTE_A_STATUS, v);
		chk("busy bit", v[0], 1'b1);
		wr(`BTE_A_FG, 32'h1234_5678);
		idle();
		slow <= 1'b0;
		rd(`BTE_A_FG, v);
		chk("fg held", v, FG);
		rd(`BTE_A_DONE, v);
		chk("done count", v, 1);
		chk("copy writes", n_wr, 4);
		for (int i = 0; i < 4; i++) begin
			off = 32'(i / 2 * 256 + i % 2 * 16);
			chk("copy addr", w_a[i], DB + 32'h0000_0130 + off);
			chk("copy data", w_d[i], {2{mw(32'h0003_0040 + off)}});
			chk("copy mask", w_m[i], 32'h0000_FFFF);
		end
		$display("test copy done");
	endtask
	task automatic t_rop();
		logic [7:0] r [6] = '{8'h00, 8'hFF, 8'h66, 8'h88, 8'hCC, 8'h5A};
		for (int i = 0; i < 6; i++) begin
			d0 <= mk(32'h0004_0000, 12'h000, 12'h000, 12'h001, 12'h001, r[i],
				BTE_K_MEM, 4'h0);
			start(16'h0001);
			idle();
			chk("rop data", w_d[0],
				{2{rop_f(r[i], mw(32'h0004_0000), mw(DB))}});
		end
		$display("test rop done");
	endtask
	task automatic t_clip();
		wr(`BTE_A_CLIPX, 32'hFFFF_0010);
		d0 <= mk(32'h0005_0000, 12'h000, 12'h000, 12'h002, 12'h001, 8'hCC,
			BTE_K_MEM, 4'h0);
		start(16'h0001);
		idle();
		chk("clip bytes", bytes, 16);
		chk("clip addr", w_a[(n_wr + 3) % 4], DB + 32'h0000_0010);
		wr(`BTE_A_CLIPX, `BTE_R_CLIPX);
		$display("test clip done");
	endtask
	task automatic t_rev();
		logic [127:0] dsc;
		dsc = mk(32'h0006_0000, 12'h000, 12'h000, 12'h002, 12'h001, 8'hCC,
			BTE_K_MEM, 4'h0);
		dsc[`BTE_D_XNEG]  = 1'b1;
		dsc[`BTE_D_SHIFT] = 4'h4;
		d0 <= dsc;
		start(16'h0001);
		idle();
		chk("rev writes", n_wr, 2);
		chk("rev first addr", w_a[0], DB + 32'h0000_0010);
		chk("rev first data", w_d[0],
			{2{128'h0006_0020_3006_0010_2006_0010_1006_0010}});
		chk("rev last addr", w_a[1], DB);
		chk("rev last data", w_d[1],
			{2{128'h0006_0010_3006_0000_2006_0000_1006_0000}});
		$display("test reverse done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		wr(`BTE_A_IBASE, 32'h0000_1000);
		wr(`BTE_A_DBASE, DB);
		wr(`BTE_A_PITCH, 32'h0100_0100);
		wr(`BTE_A_FG, FG);
		t_batch();
		t_copy();
		t_rop();
		t_clip();
		t_rev();
		end_of_test();
	end
endmodule
`default_nettype wire
